// [sdr_pkg.sv]
// Package: constants and types for the sample delay ramp and timestamp block
package sdr_pkg;
  localparam int          SDR_SAMPLE_W    = 12;  // Converter sample width
  localparam int          SDR_DELAY_W     = 8;   // Coarse and fine width
  localparam int          SDR_LATENCY     = 4;   // Converter core latency
  localparam int          SDR_RAMP_PERIOD = 384; // Cycles per ramp tick
  localparam int          SDR_CNT_W       = 9;   // Ramp tick counter width
  localparam logic [8:0]  SDR_CNT_LAST    = 9'(SDR_RAMP_PERIOD - 1); // Last
  localparam logic [7:0]  SDR_STEP_SLOW   = 8'h01;  // Slow step size
  localparam logic [7:0]  SDR_STEP_FAST   = 8'h04;  // Fast step size
  localparam logic [7:0]  SDR_DELAY_RST   = 8'h00;  // Delay reset value
  localparam logic [11:0] SDR_SAMPLE_RST  = 12'h000; // Sample reset value
  // Sample format selection
  typedef enum logic {SDR_FMT12, SDR_FMT8} sdr_fmt_t;
endpackage

// [sdr_top.sv]
// Sample edge selection, aperture delay ramp and trigger timestamp logic
`timescale 1ns/1ps
module sdr_top #(
  parameter int LATENCY = sdr_pkg::SDR_LATENCY
) (
  input  wire logic                   core_clk_in,            // Device clock
  input  wire logic                   rst_in,                 // Sync reset
  input  wire logic                   trigger_mark_input_in,  // Async trigger
  input  wire logic                   timestamp_enable_in,    // Mark enable
  input  wire sdr_pkg::sdr_fmt_t      sample_format_in,       // 12 or 8 bit
  input  wire logic                   single_channel_in,      // Both edges
  input  wire logic [11:0]            sample_rise_in,         // Rising sample
  input  wire logic [11:0]            sample_fall_in,         // Falling sample
  input  wire logic                   sample_valid_in,        // Samples valid
  input  wire logic                   clock_invert_delay_in,  // Invert clock
  input  wire logic [7:0]             coarse_aperture_delay_in, // Coarse set
  input  wire logic                   coarse_write_in,        // Coarse strobe
  input  wire logic [7:0]             fine_aperture_delay_in, // Fine set
  input  wire logic                   delay_ramp_enable_in,   // Ramp enable
  input  wire logic                   delay_ramp_speed_in,    // 1 = fast
  output logic [11:0]                 stream_a_out,           // First sample
  output logic [11:0]                 stream_b_out,           // Second sample
  output logic                        stream_b_used_out,      // B carries data
  output logic                        stream_valid_out,       // Output valid
  output logic                        clock_invert_out,       // Invert active
  output logic [7:0]                  coarse_active_out,      // Active coarse
  output logic [7:0]                  fine_active_out,        // Active fine
  output logic [8:0]                  total_delay_steps_out,  // Coarse + fine
  output logic                        ramp_busy_out           // Ramp running
);
  import sdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser, first stage read only by second
  logic trig_meta_reg;  // First stage
  logic trig_sync_reg;  // Second stage

  // Two-flop capture of asynchronous trigger
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
    end else begin
      trig_meta_reg <= trigger_mark_input_in;
      trig_sync_reg <= trig_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Marking of samples, before the shared latency line
  logic [11:0] mark_a;  // Marked first sample
  logic [11:0] mark_b;  // Marked second sample

  // Insert trigger into LSB of word per format
  always_comb begin
    mark_a = sample_rise_in;
    mark_b = sample_fall_in;
    if (timestamp_enable_in) begin
      if (sample_format_in == SDR_FMT12) begin
        mark_a = {sample_rise_in[11:1], trig_sync_reg};
        mark_b = {sample_fall_in[11:1], trig_sync_reg};
      end else begin
        mark_a = {4'h0, sample_rise_in[11:5], trig_sync_reg};
        mark_b = {4'h0, sample_fall_in[11:5], trig_sync_reg};
      end
    end else if (sample_format_in == SDR_FMT8) begin
      mark_a = {4'h0, sample_rise_in[11:4]};
      mark_b = {4'h0, sample_fall_in[11:4]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency line shared by data and trigger bit
  logic [11:0] pipe_a_reg [LATENCY];  // First sample stages
  logic [11:0] pipe_b_reg [LATENCY];  // Second sample stages
  logic        pipe_u_reg [LATENCY];  // Both-edge flag stages
  logic        pipe_v_reg [LATENCY];  // Valid stages

  // Same depth for sample and trigger keeps alignment
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_a_reg[i] <= SDR_SAMPLE_RST;
        pipe_b_reg[i] <= SDR_SAMPLE_RST;
        pipe_u_reg[i] <= 1'b0;
        pipe_v_reg[i] <= 1'b0;
      end
    end else begin
      pipe_a_reg[0] <= mark_a;
      pipe_b_reg[0] <= single_channel_in ? mark_b : SDR_SAMPLE_RST;
      pipe_u_reg[0] <= single_channel_in;
      pipe_v_reg[0] <= sample_valid_in;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_a_reg[i] <= pipe_a_reg[i-1];
        pipe_b_reg[i] <= pipe_b_reg[i-1];
        pipe_u_reg[i] <= pipe_u_reg[i-1];
        pipe_v_reg[i] <= pipe_v_reg[i-1];
      end
    end
  end

  assign stream_a_out      = pipe_a_reg[LATENCY-1];
  assign stream_b_out      = pipe_b_reg[LATENCY-1];
  assign stream_b_used_out = pipe_u_reg[LATENCY-1];
  assign stream_valid_out  = pipe_v_reg[LATENCY-1];

  ////////////////////////////////////////////////////////////////////////////
  // Inversion and fine delay, applied directly
  logic       inv_reg;   // Active inversion
  logic [7:0] fine_reg;  // Active fine delay

  // Live update of inversion and fine setting
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      inv_reg  <= 1'b0;
      fine_reg <= SDR_DELAY_RST;
    end else begin
      inv_reg  <= clock_invert_delay_in;
      fine_reg <= fine_aperture_delay_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coarse delay ramp
  logic [7:0]           coarse_reg;   // Active coarse delay
  logic [7:0]           target_reg;   // Ramp target
  logic                 busy_reg;     // Ramp running
  logic [SDR_CNT_W-1:0] cnt_reg;      // Tick counter
  logic                 tick;         // End of 384-cycle period
  logic [7:0]           step;         // Step size
  logic [7:0]           diff;         // Remaining distance

  assign tick = busy_reg && (cnt_reg == SDR_CNT_LAST);
  assign step = delay_ramp_speed_in ? SDR_STEP_FAST : SDR_STEP_SLOW;
  assign diff = (target_reg > coarse_reg) ? target_reg - coarse_reg
                                          : coarse_reg - target_reg;

  // Tick counter runs only during a ramp
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !busy_reg || coarse_write_in) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
    end
  end

  // Coarse update: direct or ramped toward target
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      coarse_reg <= SDR_DELAY_RST;
      target_reg <= SDR_DELAY_RST;
      busy_reg   <= 1'b0;
    end else if (coarse_write_in) begin
      target_reg <= coarse_aperture_delay_in;
      if (delay_ramp_enable_in) begin
        busy_reg <= (coarse_aperture_delay_in != coarse_reg);
      end else begin
        coarse_reg <= coarse_aperture_delay_in;
        busy_reg   <= 1'b0;
      end
    end else if (tick) begin
      if (diff <= step) begin
        coarse_reg <= target_reg;
        busy_reg   <= 1'b0;
      end else if (target_reg > coarse_reg) begin
        coarse_reg <= coarse_reg + step;
      end else begin
        coarse_reg <= coarse_reg - step;
      end
    end
  end

  assign clock_invert_out      = inv_reg;
  assign coarse_active_out     = coarse_reg;
  assign fine_active_out       = fine_reg;
  assign total_delay_steps_out = {1'b0, coarse_reg} + {1'b0, fine_reg};
  assign ramp_busy_out         = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_ts_off;
    @(posedge core_clk_in) disable iff (rst_in)
    !timestamp_enable_in && sample_format_in == SDR_FMT12
      |-> mark_a == sample_rise_in;
  endproperty
  a_ts_off: assert property (p_ts_off) else $error("mark while off");

  property p_ts12;
    @(posedge core_clk_in) disable iff (rst_in)
    timestamp_enable_in && sample_format_in == SDR_FMT12
      |-> mark_a[0] == trig_sync_reg && mark_a[11:1] == sample_rise_in[11:1];
  endproperty
  a_ts12: assert property (p_ts12) else $error("bad 12-bit mark");

  property p_ts8;
    @(posedge core_clk_in) disable iff (rst_in)
    timestamp_enable_in && sample_format_in == SDR_FMT8
      |-> mark_a[0] == trig_sync_reg && mark_a[11:8] == 4'h0;
  endproperty
  a_ts8: assert property (p_ts8) else $error("bad 8-bit mark");

  property p_lat;
    @(posedge core_clk_in) disable iff (rst_in)
    !rst_in [*4] |=> stream_a_out == $past(mark_a, LATENCY);
  endproperty
  a_lat: assert property (p_lat) else $error("latency mismatch");

  property p_sync;
    @(posedge core_clk_in) disable iff (rst_in)
    !rst_in [*3] |-> trig_sync_reg == $past(trigger_mark_input_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth");

  property p_dual;
    @(posedge core_clk_in) disable iff (rst_in)
    !single_channel_in |=> pipe_b_reg[0] == SDR_SAMPLE_RST && !pipe_u_reg[0];
  endproperty
  a_dual: assert property (p_dual) else $error("dual uses fall");

  property p_tick;
    @(posedge core_clk_in) disable iff (rst_in)
    $rose(busy_reg) |-> !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("early ramp step");

  property p_step;
    @(posedge core_clk_in) disable iff (rst_in)
    busy_reg && !coarse_write_in && !tick |=> $stable(coarse_reg);
  endproperty
  a_step: assert property (p_step) else $error("coarse moved");

  property p_stop;
    @(posedge core_clk_in) disable iff (rst_in)
    busy_reg && tick && !coarse_write_in && diff <= step
      |=> coarse_reg == $past(target_reg) && !busy_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("ramp overshoot");

  property p_start;
    @(posedge core_clk_in) disable iff (rst_in)
    coarse_write_in && delay_ramp_enable_in
      && coarse_aperture_delay_in != coarse_reg |=> busy_reg;
  endproperty
  a_start: assert property (p_start) else $error("no ramp start");

  c_ramp: cover property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(busy_reg));
  c_mark: cover property (@(posedge core_clk_in) disable iff (rst_in)
    stream_valid_out && stream_a_out[0] && timestamp_enable_in);
  c_single: cover property (@(posedge core_clk_in) disable iff (rst_in)
    stream_b_used_out && stream_valid_out);
endmodule

// [sdr_trig_model.sv]
// Behavioural model of the external trigger source
`timescale 1ns/1ps
module sdr_trig_model #(
  parameter real SKEW_NS = 3.3  // Offset of trigger edges from the clock grid
) (
  input  wire logic level_in,               // Requested trigger level
  output logic      trigger_mark_input_out  // Trigger as seen at the pin
);
  ////////////////////////////////////////////////////////////////////////////
  // Trigger edges land off the clock grid, a fixed SKEW_NS after each level change
  assign #(SKEW_NS) trigger_mark_input_out = level_in;
  // Plain levels only: no periodic reference, no decimating formats
endmodule

// [sdr_top_tb.sv]
// Self-checking testbench for the sample delay ramp and timestamp block
`timescale 1ns/1ps
module sdr_top_tb;
  import sdr_pkg::*;
  logic        clk, rst, lvl, trig, ts_en, single, valid, inv, cwr;
  logic        ramp_en, fast, b_used, s_valid, inv_act, busy;
  sdr_fmt_t    fmt;                  // Output format
  logic [11:0] rise, fall, sa, sb;  // Samples in and out
  logic [7:0]  coarse, fine, c_act, f_act;
  logic [8:0]  total;                // Summed delay
  int          bad_count, checks, wcyc;
  int          cyc = 0;              // Rising edges seen
  ////////////////////////////////////////////////////////////////////////////
  // Clock, edge counter, trigger source and device
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  sdr_trig_model trg (.level_in(lvl), .trigger_mark_input_out(trig));
  sdr_top uut (
    .core_clk_in(clk), .rst_in(rst), .trigger_mark_input_in(trig),
    .timestamp_enable_in(ts_en), .sample_format_in(fmt),
    .single_channel_in(single), .sample_rise_in(rise),
    .sample_fall_in(fall), .sample_valid_in(valid),
    .clock_invert_delay_in(inv), .coarse_aperture_delay_in(coarse),
    .coarse_write_in(cwr), .fine_aperture_delay_in(fine),
    .delay_ramp_enable_in(ramp_en), .delay_ramp_speed_in(fast),
    .stream_a_out(sa), .stream_b_out(sb), .stream_b_used_out(b_used),
    .stream_valid_out(s_valid), .clock_invert_out(inv_act),
    .coarse_active_out(c_act), .fine_active_out(f_act),
    .total_delay_steps_out(total), .ramp_busy_out(busy));
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function logic [11:0] fmt_exp(sdr_fmt_t f, logic t_on, logic t,
                                logic [11:0] s);
    if (f == SDR_FMT12) return t_on ? {s[11:1], t} : s;
    return t_on ? {4'h0, s[11:5], t} : {4'h0, s[11:4]};
  endfunction
  // Coarse write; wcyc marks the edge that takes it
  task wr(input logic [7:0] v);
    @(negedge clk);
    coarse = v;
    cwr = 1'b1;
    @(posedge clk);
    #1 wcyc = cyc;
    @(negedge clk);
    cwr = 1'b0;
  endtask
  // Settle just after edge wcyc + n
  task at(input int n);
    while (cyc < wcyc + n) @(negedge clk);
  endtask
  task test_done;
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run of about 1700 cycles
  initial begin
    #100us;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, lvl, ts_en, single, valid, inv, cwr, ramp_en, fast} = 9'h100;
    fmt = SDR_FMT12;
    {rise, fall, coarse, fine} = '0;
    repeat (4) @(negedge clk);
    check(sa, 12'h000);
    check(c_act, 8'h00);
    check(busy, 1'b0);
    rst = 1'b0;
    $display("Test reset done");
    // Every format, mark enable, trigger level and channel mode
    valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      fmt = sdr_fmt_t'(i[0]);
      ts_en = i[1];
      lvl = i[2];
      single = i[3];
      rise = 12'hA5C + 12'(i * 37);
      fall = 12'h3B1 - 12'(i * 53);
      repeat (8) @(negedge clk);
      check(sa, fmt_exp(fmt, ts_en, lvl, rise));
      check(b_used, single);
      if (single) check(sb, fmt_exp(fmt, ts_en, lvl, fall));
      check(s_valid, 1'b1);
    end
    $display("Test formats done");
    // Sample and valid appear exactly LATENCY edges later
    fmt = SDR_FMT12;
    {ts_en, single, rise} = {2'b00, 12'h123};
    repeat (6) @(negedge clk);
    {rise, valid} = {12'hABC, 1'b0};
    for (int k = 1; k < 4; k++) begin
      @(negedge clk);
      check(sa, 12'h123);
      check(s_valid, 1'b1);
    end
    @(negedge clk);
    check(sa, 12'hABC);
    check(s_valid, 1'b0);
    $display("Test latency done");
    // Invert, fine and direct coarse, summed at the top setting
    {inv, fine} = {1'b1, 8'h21};
    @(negedge clk);
    @(negedge clk);
    check(inv_act, 1'b1);
    check(f_act, 8'h21);
    wr(8'hFF);
    at(1);
    check(c_act, 8'hFF);
    check(total, 9'h120);
    wr(8'h00);
    at(1);
    check(c_act, 8'h00);
    $display("Test direct delay done");
    // Fast ramp 0 to 6: step of four, then clamped step of two
    {ramp_en, fast} = 2'b11;
    wr(8'h06);
    at(1);
    check(busy, 1'b1);
    at(383);
    check(c_act, 8'h00);
    at(384);
    check(c_act, 8'h04);
    at(767);
    check(busy, 1'b1);
    at(768);
    check(c_act, 8'h06);
    check(busy, 1'b0);
    // Slow ramp down, then a rewrite mid-ramp restarts the tick
    fast = 1'b0;
    wr(8'h04);
    at(384);
    check(c_act, 8'h05);
    wr(8'h06);
    at(383);
    check(c_act, 8'h05);
    at(384);
    check(c_act, 8'h06);
    check(busy, 1'b0);
    check(total, 9'h027);
    $display("Test ramp done");
    test_done;
  end
endmodule
